// [hdl/cfre_params.svh]
/*
  Named constants for the code flash row erase and write sequencer:
  serial command codes, control register bit positions, core opcodes,
  special register addresses, timing and bus register offsets.
  Assumes it is included by bare name from each design file.
*/
`ifndef CFRE_PARAMS_SVH
`define CFRE_PARAMS_SVH

// ----------------------------------------------------------------
// serial frame
// ----------------------------------------------------------------
`define CFRE_CMD_CORE 4'h0
`define CFRE_CMD_SHIFT_LATCH 4'h2
`define CFRE_CMD_WRITE 4'hC
`define CFRE_CMD_WRITE_INC2 4'hD
`define CFRE_CMD_WRITE_START 4'hF
`define CFRE_CMD_LAST 5'h03
`define CFRE_OUT_FIRST 5'h0C
`define CFRE_FRAME_LAST 5'h13

// ----------------------------------------------------------------
// memory control register bits and special register addresses
// ----------------------------------------------------------------
`define CFRE_MCR_CODE 7
`define CFRE_MCR_CFG 6
`define CFRE_MCR_ERASE 4
`define CFRE_MCR_WRITE_EN 2
`define CFRE_MCR_WR 1
`define CFRE_MCR_RESET 8'h00
`define CFRE_SFR_MCR 8'hA6
`define CFRE_SFR_PTR_U 8'hF8
`define CFRE_SFR_PTR_H 8'hF7
`define CFRE_SFR_PTR_L 8'hF6
`define CFRE_SFR_LATCH 8'hF5

// ----------------------------------------------------------------
// core instruction opcodes
// ----------------------------------------------------------------
`define CFRE_OP_MOVLW 8'h0E
`define CFRE_OP_MOVWF 8'h6E
`define CFRE_OP_CLRF 8'h6A
`define CFRE_OP_MOVF_W 8'h50
`define CFRE_OP_NOP 16'h0000
`define CFRE_OP_BSF 4'h8
`define CFRE_OP_BCF 4'h9

// ----------------------------------------------------------------
// geometry and timing
// ----------------------------------------------------------------
`define CFRE_ROW_SHIFT 6
`define CFRE_PTR_STEP 22'h000002
`define CFRE_CLK_PERIOD_NS 5
`define CFRE_ERASE_TIME_NS 10000
`define CFRE_ERASE_CYCLES \
  ((`CFRE_ERASE_TIME_NS + `CFRE_CLK_PERIOD_NS - 1) / `CFRE_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// bus register map
// ----------------------------------------------------------------
`define CFRE_REG_PROTECT 4'h0
`define CFRE_REG_STATUS 4'h4
`define CFRE_REG_POINTER 4'h8
`define CFRE_RESP_OKAY 2'h0
`define CFRE_RESP_SLVERR 2'h2

`endif

// [hdl/cfre_pkg.sv]
/*
  Types shared by the sequencer files.
  Assumes nothing of its surroundings.
*/
package cfre_pkg;
  typedef logic [21:0] cfre_ptr_t;
  typedef logic [7:0] cfre_byte_t;
  typedef enum {st_idle, st_nop1, st_nop2, st_erasing} cfre_erase_e;
endpackage

// [hdl/cfre_link_if.sv]
/*
  Bundle between the serial front end and the sequencer core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface cfre_link_if;
  logic rise;
  logic fall;
  logic cmd_done;
  logic frame_done;
  logic [4:0] bit_idx;
  logic [3:0] cmd;
  logic [15:0] operand;
  logic [7:0] tx_byte;
  modport front(output rise, fall, cmd_done, frame_done, bit_idx, cmd, operand,
    input tx_byte);
  modport core(input rise, fall, cmd_done, frame_done, bit_idx, cmd, operand,
    output tx_byte);
endinterface

// [hdl/cfre_serial_front.sv]
/*
  Serial front end: synchronises the programming clock and data pins,
  assembles 4-bit command and 16-bit operand frames, and shifts the
  table latch out for the shift-out command.
  Assumes the pins are asynchronous and the system clock is far faster.
*/
`timescale 1ns/1ps
`include "cfre_params.svh"
module cfre_serial_front
  import cfre_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic prog_clock_pin,
  input wire logic prog_data_in,
  output logic prog_data_out,
  output logic prog_data_oe,
  cfre_link_if.front link
);
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
  logic [19:0] shift;
  logic [4:0] idx;
  logic [4:0] out_sel;
  logic rise_w, fall_w, cmd_w, last_w;

  assign rise_w = clk_s2 & ~clk_s3;
  assign fall_w = ~clk_s2 & clk_s3;
  assign cmd_w = fall_w && (idx == `CFRE_CMD_LAST);
  assign last_w = fall_w && (idx == `CFRE_FRAME_LAST);
  assign out_sel = idx - `CFRE_OUT_FIRST;
  assign link.rise = rise_w;
  assign link.fall = fall_w;
  assign link.bit_idx = idx;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else begin
      clk_s1 <= prog_clock_pin;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= prog_data_in;
      dat_s2 <= dat_s1;
    end
  end

  // ----------------------------------------------------------------
  // frame assembly, sampled on falling edges, least significant first
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idx <= 5'h00;
      shift <= 20'h00000;
    end else if (fall_w) begin
      idx <= last_w ? 5'h00 : idx + 5'h01;
      shift <= {dat_s2, shift[19:1]};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link.cmd <= 4'h0;
      link.operand <= 16'h0000;
      link.cmd_done <= 1'b0;
      link.frame_done <= 1'b0;
    end else begin
      link.cmd_done <= cmd_w;
      link.frame_done <= last_w;
      if (cmd_w) link.cmd <= {dat_s2, shift[19:17]};
      if (last_w) link.operand <= {dat_s2, shift[19:5]};
    end
  end

  // ----------------------------------------------------------------
  // shift-out: driven on rising edges of the last eight clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prog_data_out <= 1'b0;
      prog_data_oe <= 1'b0;
    end else if (last_w) begin
      prog_data_oe <= 1'b0;
    end else if (rise_w && link.cmd == `CFRE_CMD_SHIFT_LATCH && idx >= `CFRE_OUT_FIRST) begin
      prog_data_oe <= 1'b1;
      prog_data_out <= link.tx_byte[out_sel[2:0]];
    end
  end

  frame_len_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    link.frame_done |-> (idx == 5'h00 && $past(idx, 2) == `CFRE_FRAME_LAST))
    else $error("frame did not close after twenty bits");
  shift_drive_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(prog_data_oe) |-> (link.cmd == `CFRE_CMD_SHIFT_LATCH && idx == `CFRE_OUT_FIRST))
    else $error("data pin driven outside the shift-out command");
endmodule // cfre_serial_front

// [hdl/cfre_row_erase_write.sv]
/*
  Code flash row erase and buffered write sequencer, device side.
  Executes the small set of core instructions used by the programmer,
  runs the self-timed row erase and the externally timed programming
  pulse, and exposes protection and status over AXI4-Lite.
  Assumes reset_n is asserted until programming mode is entered, and
  that the flash array obeys the erase and program strobes given here.
*/
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "cfre_params.svh"
module cfre_row_erase_write
  import cfre_pkg::*;
#(
  parameter int WBUF_BYTES = 16,
  parameter int PROT_BLOCKS = 4,
  parameter int BLOCK_SHIFT = 12,
  parameter cfre_ptr_t MEM_BYTES = 22'h004000,
  parameter int ERASE_CYCLES = `CFRE_ERASE_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic prog_clock_pin,
  input wire logic prog_data_in,
  output logic prog_data_out,
  output logic prog_data_oe,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_erase_busy,
  output cfre_ptr_t flash_row_addr,
  output logic flash_prog_pulse,
  output cfre_ptr_t flash_prog_addr,
  output logic [WBUF_BYTES*8-1:0] flash_prog_data
);
  localparam int BI = $clog2(WBUF_BYTES);
  localparam int PB = $clog2(PROT_BLOCKS);
  localparam int CW = $clog2(ERASE_CYCLES + 1);
  localparam logic [CW-1:0] ERASE_LOAD = CW'(ERASE_CYCLES - 1);

  cfre_link_if link();

  cfre_serial_front u_front (
    .clock(clock),
    .reset_n(reset_n),
    .prog_clock_pin(prog_clock_pin),
    .prog_data_in(prog_data_in),
    .prog_data_out(prog_data_out),
    .prog_data_oe(prog_data_oe),
    .link(link)
  );

  cfre_byte_t w_reg, memory_control_reg, table_latch;
  cfre_ptr_t table_pointer;
  cfre_byte_t wbuf [WBUF_BYTES];
  logic [PROT_BLOCKS-1:0] protect;
  cfre_erase_e state;
  logic [CW-1:0] erase_count;
  logic prog_armed;

  // ----------------------------------------------------------------
  // core instruction decode
  // ----------------------------------------------------------------
  wire [7:0] op_hi = link.operand[15:8];
  wire [7:0] op_lo = link.operand[7:0];
  wire is_core = link.frame_done && link.cmd == `CFRE_CMD_CORE;
  wire is_movlw = is_core && op_hi == `CFRE_OP_MOVLW;
  wire is_movwf = is_core && op_hi == `CFRE_OP_MOVWF;
  wire is_clrf = is_core && op_hi == `CFRE_OP_CLRF;
  wire is_movf = is_core && op_hi == `CFRE_OP_MOVF_W;
  wire is_bsf = is_core && op_hi[7:4] == `CFRE_OP_BSF;
  wire is_bcf = is_core && op_hi[7:4] == `CFRE_OP_BCF;
  wire is_start = link.frame_done && link.cmd == `CFRE_CMD_WRITE_START;
  wire is_twrite = link.frame_done && (link.cmd == `CFRE_CMD_WRITE ||
    link.cmd == `CFRE_CMD_WRITE_INC2 || link.cmd == `CFRE_CMD_WRITE_START);
  wire is_inc2 = link.frame_done && link.cmd == `CFRE_CMD_WRITE_INC2;
  wire [7:0] bit_mask = 8'h01 << op_hi[3:1];
  wire [7:0] wr_mask = 8'h01 << `CFRE_MCR_WR;

  // hardware clear of write start, folded in so a same-cycle BSF/BCF keeps it
  wire wr_clear;
  wire [7:0] mcr_live = wr_clear ? (memory_control_reg & ~wr_mask) : memory_control_reg;
  wire [7:0] sfr_rd =
    (op_lo == `CFRE_SFR_MCR) ? mcr_live :
    (op_lo == `CFRE_SFR_PTR_U) ? {2'h0, table_pointer[21:16]} :
    (op_lo == `CFRE_SFR_PTR_H) ? table_pointer[15:8] :
    (op_lo == `CFRE_SFR_PTR_L) ? table_pointer[7:0] :
    (op_lo == `CFRE_SFR_LATCH) ? table_latch : 8'h00;
  wire sfr_we = is_movwf | is_clrf | is_bsf | is_bcf;
  wire [7:0] sfr_wd = is_movwf ? w_reg :
    is_bsf ? (sfr_rd | bit_mask) :
    is_bcf ? (sfr_rd & ~bit_mask) : 8'h00;
  wire mcr_we = sfr_we && op_lo == `CFRE_SFR_MCR;

  assign link.tx_byte = table_latch;

  // ----------------------------------------------------------------
  // access check: code space, writes enabled, in memory, unprotected
  // ----------------------------------------------------------------
  wire [PB-1:0] blk = table_pointer[BLOCK_SHIFT +: PB];
  wire in_mem = table_pointer < MEM_BYTES;
  wire wr_ok = memory_control_reg[`CFRE_MCR_CODE] & ~memory_control_reg[`CFRE_MCR_CFG] &
    memory_control_reg[`CFRE_MCR_WRITE_EN] & in_mem & ~protect[blk];
  wire erase_ok = wr_ok & memory_control_reg[`CFRE_MCR_ERASE];
  wire nop2_hit = state == st_nop2 && link.cmd_done;
  wire erase_go = nop2_hit && link.cmd == `CFRE_CMD_CORE && erase_ok;
  wire erase_end = state == st_erasing && erase_count == '0;
  assign wr_clear = erase_end || (nop2_hit && !erase_go);
  wire prog_go = prog_armed && link.rise && link.bit_idx == `CFRE_CMD_LAST &&
    state == st_idle;

  // ----------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      w_reg <= 8'h00;
      table_latch <= 8'h00;
    end else begin
      if (is_movlw) w_reg <= op_lo;
      else if (is_movf) w_reg <= sfr_rd;
      if (sfr_we && op_lo == `CFRE_SFR_LATCH) table_latch <= sfr_wd;
    end
  end

  // a software set of write start beats the hardware clear in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) memory_control_reg <= `CFRE_MCR_RESET;
    else if (mcr_we) memory_control_reg <= sfr_wd;
    else if (wr_clear) memory_control_reg <= mcr_live;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) table_pointer <= '0;
    else if (sfr_we && op_lo == `CFRE_SFR_PTR_U) table_pointer[21:16] <= sfr_wd[5:0];
    else if (sfr_we && op_lo == `CFRE_SFR_PTR_H) table_pointer[15:8] <= sfr_wd;
    else if (sfr_we && op_lo == `CFRE_SFR_PTR_L) table_pointer[7:0] <= sfr_wd;
    else if (is_inc2) table_pointer <= table_pointer + `CFRE_PTR_STEP;
  end

  // write buffer: low byte to even address, high byte to odd
  always_ff @(posedge clock) begin
    if (is_twrite) begin
      wbuf[{table_pointer[BI-1:1], 1'b0}] <= op_lo;
      wbuf[{table_pointer[BI-1:1], 1'b1}] <= op_hi;
    end
  end

  always_comb begin
    flash_prog_data = '0;
    for (int i = 0; i < WBUF_BYTES; i++) flash_prog_data[i*8 +: 8] = wbuf[i];
  end

  // ----------------------------------------------------------------
  // self-timed row erase
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
      erase_count <= '0;
    end else begin
      case (state)
        st_idle: if (memory_control_reg[`CFRE_MCR_WR] && !prog_armed) state <= st_nop1;
        st_nop1: if (link.frame_done) state <= st_nop2;
        st_nop2: if (link.cmd_done) begin
          state <= erase_go ? st_erasing : st_idle;
          erase_count <= ERASE_LOAD;
        end
        st_erasing: if (erase_end) state <= st_idle;
          else erase_count <= erase_count - 1'b1;
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_erase_busy <= 1'b0;
      flash_row_addr <= '0;
    end else begin
      if (erase_go) flash_erase_busy <= 1'b1;
      else if (erase_end) flash_erase_busy <= 1'b0;
      if (erase_go) flash_row_addr <= {table_pointer[21:`CFRE_ROW_SHIFT],
        {`CFRE_ROW_SHIFT{1'b0}}};
    end
  end

  // ----------------------------------------------------------------
  // externally timed programming pulse
  // ----------------------------------------------------------------
  // the pulse follows the pin, so its width is whatever the programmer holds
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prog_armed <= 1'b0;
      flash_prog_pulse <= 1'b0;
      flash_prog_addr <= '0;
    end else begin
      if (is_start) prog_armed <= wr_ok;
      else if (prog_go || link.frame_done) prog_armed <= 1'b0;
      if (prog_go) flash_prog_pulse <= 1'b1;
      else if (link.fall) flash_prog_pulse <= 1'b0;
      if (prog_go) flash_prog_addr <= {table_pointer[21:BI], {BI{1'b0}}};
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_hit = aw_addr == `CFRE_REG_PROTECT;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire rd_hit = s_axi_araddr == `CFRE_REG_PROTECT || s_axi_araddr == `CFRE_REG_STATUS ||
    s_axi_araddr == `CFRE_REG_POINTER;
  wire [31:0] status_word = {21'h000000, prog_armed, flash_prog_pulse, flash_erase_busy,
    memory_control_reg};
  wire [31:0] rd_word =
    (s_axi_araddr == `CFRE_REG_PROTECT) ? 32'(protect) :
    (s_axi_araddr == `CFRE_REG_STATUS) ? status_word :
    (s_axi_araddr == `CFRE_REG_POINTER) ? 32'(table_pointer) : 32'h00000000;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_go) w_held <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      protect <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFRE_RESP_OKAY;
    end else begin
      if (wr_go && wr_hit && w_lane0) protect <= w_data[PROT_BLOCKS-1:0];
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `CFRE_RESP_OKAY : `CFRE_RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CFRE_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `CFRE_RESP_OKAY : `CFRE_RESP_SLVERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mcr_code_bit_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (is_bsf && op_lo == `CFRE_SFR_MCR && op_hi[3:1] == 3'(`CFRE_MCR_CODE))
    |=> memory_control_reg[`CFRE_MCR_CODE])
    else $error("code select bit not set by its bit-set instruction");
  erase_guard_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(flash_erase_busy) |-> $past(erase_ok))
    else $error("erase started on a protected or disabled target");
  erase_start_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (state == st_nop2 && link.cmd_done && link.cmd == `CFRE_CMD_CORE && erase_ok)
    |=> flash_erase_busy ##1 flash_erase_busy)
    else $error("erase did not start on the second no-op");
  erase_hold_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(flash_erase_busy) |-> flash_erase_busy[*8])
    else $error("row erase ended too early");
  wr_clear_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $fell(flash_erase_busy) |-> !memory_control_reg[`CFRE_MCR_WR])
    else $error("write start still set after erase completed");
  row_align_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(flash_erase_busy) |-> (flash_row_addr[`CFRE_ROW_SHIFT-1:0] == '0 &&
    flash_row_addr[21:`CFRE_ROW_SHIFT] == $past(table_pointer[21:`CFRE_ROW_SHIFT])))
    else $error("erased row does not hold the table pointer");
  prog_start_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    prog_go |=> flash_prog_pulse)
    else $error("programming pulse missed the fourth clock");
  prog_end_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (flash_prog_pulse && link.fall) |=> !flash_prog_pulse)
    else $error("programming pulse outlived the falling clock");
  region_align_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(flash_prog_pulse) |-> (flash_prog_addr[BI-1:0] == '0 &&
    flash_prog_addr[21:BI] == $past(table_pointer[21:BI])))
    else $error("programmed region does not hold the table pointer");
endmodule // cfre_row_erase_write

// [verif/cfre_prog_model.sv]
/*
  Programmer model: drives the serial clock and data pins, lsb first.
  Assumes the device samples on falling clock edges and drives on rises.
*/
`timescale 1ns/1ps
module cfre_prog_model (
  output logic clk_pin,
  output wire logic data_pin,
  input wire logic dev_out,
  input wire logic dev_oe
);
  logic drv = 1'b0;
  logic [7:0] shifted;
  assign data_pin = dev_oe ? dev_out : drv;
  initial clk_pin = 1'b0;
  task automatic frame(input logic [3:0] c, input logic [15:0] d, input int hold);
    logic [19:0] b;
    b = {d, c};
    for (int i = 0; i < 20; i++) begin
      // released bits toggle so a stale level never passes for data
      drv = (c == 4'h2 && i > 11) ? ~drv : b[i];
      clk_pin = 1'b1;
      #(62.5 + ((i == 3) ? hold : 0));
      clk_pin = 1'b0;
      if (i > 11) shifted[i-12] = data_pin;
      #62.5;
    end
  endtask
  task automatic enable();
    frame(4'h0, 16'h8EA6, 0);
    frame(4'h0, 16'h9CA6, 0);
    frame(4'h0, 16'h84A6, 0);
  endtask
  task automatic point(input logic [21:0] p);
    if (p[21:16] == 6'h00) frame(4'h0, 16'h6AF8, 0);
    else begin
      frame(4'h0, {8'h0E, 2'b00, p[21:16]}, 0);
      frame(4'h0, 16'h6EF8, 0);
    end
    frame(4'h0, {8'h0E, p[15:8]}, 0);
    frame(4'h0, 16'h6EF7, 0);
    frame(4'h0, {8'h0E, p[7:0]}, 0);
    frame(4'h0, 16'h6EF6, 0);
  endtask
  task automatic erase(input logic [21:0] p, output logic done);
    enable();
    point(p);
    frame(4'h0, 16'h88A6, 0);
    frame(4'h0, 16'h82A6, 0);
    frame(4'h0, 16'h0000, 0);
    frame(4'h0, 16'h0000, 0);
    done = 1'b0;
    for (int n = 0; n < 8 && !done; n++) begin
      frame(4'h0, 16'h50A6, 0);
      frame(4'h0, 16'h6EF5, 0);
      frame(4'h0, 16'h0000, 0);
      frame(4'h2, 16'h0000, 0);
      done = !shifted[1];
    end
    #1000;
  endtask
  task automatic write_row(input logic [21:0] p, input logic [15:0] d, input int hold);
    enable();
    point(p);
    frame(4'hD, ~d, 0);
    frame(4'hF, d, 0);
    frame(4'h0, 16'h0000, hold);
    #1000;
  endtask
endmodule // cfre_prog_model

// [verif/test_code_flash_row_erase_and_write.sv]
/*
  Top bench for the row erase and write sequencer.
  Assumes a 200 MHz clock and the programmer model on the serial pins.
*/
`timescale 1ns/1ps
module test_code_flash_row_erase_and_write;
  import cfre_pkg::*;
  logic clock = 0, reset_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [3:0] aa = 0;
  logic [31:0] wd = 0, rd, rdata;
  logic [1:0] resp, bresp, rresp;
  logic clk_pin, data_pin, d_out, d_oe, awr, wr, bv, arr, rv, busy, pulse, done;
  cfre_ptr_t row_addr, prog_addr, row_seen, addr_seen;
  logic [127:0] pdata;
  int busy_n = 0, pulse_n = 0, miscompares = 0, checks_done = 0;
  cfre_row_erase_write #(.ERASE_CYCLES(20)) uut (.clock(clock), .reset_n(reset_n),
    .prog_clock_pin(clk_pin), .prog_data_in(data_pin), .prog_data_out(d_out),
    .prog_data_oe(d_oe), .s_axi_awaddr(aa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(aa), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .flash_erase_busy(busy), .flash_row_addr(row_addr), .flash_prog_pulse(pulse),
    .flash_prog_addr(prog_addr), .flash_prog_data(pdata));
  cfre_prog_model prog (.clk_pin(clk_pin), .data_pin(data_pin), .dev_out(d_out),
    .dev_oe(d_oe));
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (busy) begin
      busy_n <= busy_n + 1;
      row_seen <= row_addr;
    end
    if (pulse) begin
      pulse_n <= pulse_n + 1;
      addr_seen <= prog_addr;
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // one task serves both directions: w selects write or read
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ah, wh, ok;
    @(posedge clock);
    aa <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    for (int n = 0; n < 50; n++) begin
      @(negedge clock);
      ah = (awv && awr) || (arv && arr);
      wh = wv && wr;
      ok = (bv && br) || (rv && rr);
      resp = w ? bresp : rresp;
      rd = rdata;
      @(posedge clock);
      if (ah) begin
        awv <= 0;
        arv <= 0;
      end
      if (wh) wv <= 0;
      if (ok) begin
        br <= 0;
        rr <= 0;
        return;
      end
    end
    miscompares++;
    summarize();
  endtask
  task automatic t_regs();
    axi(0, 4'h4, 0);
    chk(rd, 0);
    axi(0, 4'hC, 0);
    chk(resp, 2'h2);
  endtask
  task automatic t_erase();
    axi(1, 4'h0, 32'h8);
    chk(resp, 2'h0);
    prog.erase(22'h3FFF, done);
    chk({done, busy_n[7:0]}, 9'h100);
    axi(1, 4'h0, 32'h0);
    prog.erase(22'h3FFF, done);
    chk({done, busy_n[7:0]}, 9'h114);
    chk(row_seen, 22'h3FC0);
    axi(0, 4'h4, 0);
    chk(rd[10:0], 11'h094);
    prog.erase(22'h0045, done);
    chk(row_seen, 22'h40);
    prog.frame(4'h0, 16'h94A6, 0);
  endtask
  task automatic t_prog();
    axi(1, 4'h0, 32'h1);
    chk(resp, 2'h0);
    prog.write_row(22'h0044, 16'hA55A, 1000);
    chk(pulse_n, 0);
    axi(1, 4'h0, 32'h0);
    prog.write_row(22'h0044, 16'hA55A, 1000);
    chk(addr_seen, 22'h40);
    chk(pdata[63:32], 32'hA55A5AA5);
    axi(0, 4'h8, 0);
    chk(rd, 32'h46);
    chk(pulse_n > 208 && pulse_n < 218, 1);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1;
    repeat (4) @(posedge clock);
    t_regs();
    t_erase();
    t_prog();
    summarize();
  end
  // a hung sequence ends the run instead of stalling it
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
endmodule // test_code_flash_row_erase_and_write
